// ### sie_irq.sv
// Interrupt enable register, cause flags, serial access and interrupt pin
//
// Summary of operation
// [RULE1] Frames with top bits 01 address the enable register and its readback; sdo_oe decodes shreg[2:1], the top bits only at bit_cnt 3.
// [RULE2] Bit 13 set returns cause flags; clear returns current enables.
// [RULE3] Bit 12 set only reads; clear also loads the enable bits.
// [RULE4] Watchdog overflow in Standby interrupts if enabled, else forces reset.
// [RULE5] Every overflow without a same-cycle enable write clears the watchdog timeout enable; host re-arms it.
// [RULE6] Temperature warning change in either direction interrupts when enabled.
// [RULE7] Ground shift change in either direction interrupts when enabled.
// [RULE8] Wrong clock count interrupts when enabled; resets in Start-up or Restart.
// [RULE9] Frames without exactly 16 clocks have no register effect.
// [RULE10] Host writes zero into reserved bit 7.
// [RULE11] Any supply diagnosis bit clearing interrupts when enabled.
// [RULE12] Any CAN failure code change interrupts when enabled.
// [RULE13] Any LIN failure code change interrupts when enabled.
// [RULE14] Local wake falling edge interrupts in Normal/Flash/Standby; else resets in Standby.
// [RULE15] Local wake acts only with the global wake port enable set.
// [RULE16] Watchdog restart while switched off interrupts when enabled.
// [RULE17] CAN wake interrupts unless CAN active; disabled, resets in Standby only.
// [RULE18] LIN wake interrupts unless LIN active; disabled, resets in Standby only.
// [RULE19] Flags clear on read and reset; causes during a read are kept.
// [RULE20] After a flag read the interrupt pin is released for a minimum time.
// [RULE21] Clock count and battery failures reach the pin without rate limiting.
// [RULE22] In Normal mode non-critical causes assert the pin once per watchdog period.
// [RULE23] Each cause flag sits at its enable's bit position.
// [RULE24] Pin is low while an enabled flag pends and no release runs, unless a non-critical flag is held back in Normal mode.
`timescale 1ns/100ps
module sie_irq import sie_pkg::*; #(
	parameter int REL_CYCLES = REL_CYC
) (
	input wire logic mclk, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic sck, // Serial clock pin
	input wire logic scs_n, // Serial chip select pin, active low
	input wire logic sdi, // Serial data in pin
	output logic sdo, // Serial data out
	output logic sdo_oe, // Serial data out enable
	input wire logic local_wake_pin, // Local wake input pin
	input wire logic wake_port_en, // Global wake port enable from configuration
	input wire sie_mode_t op_mode, // Current operating mode
	input wire sie_evt_t evt, // Event and status sources
	output logic irq_out_n, // Interrupt pin, active low
	output logic reset_req // One-cycle request for a reset event
);
	initial begin
		if (REL_CYCLES < 1) begin
			$error("REL_CYCLES must be at least one");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edges
	logic [3:0] sy1;
	logic [3:0] sy2;
	logic sck_d;
	logic csn_d;
	logic wake_d;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sy1 <= 4'hf;
			sy2 <= 4'hf;
			sck_d <= 1'b1;
			csn_d <= 1'b1;
			wake_d <= 1'b1;
		end else begin
			sy1 <= {local_wake_pin, sdi, scs_n, sck};
			sy2 <= sy1;
			sck_d <= sy2[SY_SCK];
			csn_d <= sy2[SY_CSN];
			wake_d <= sy2[SY_WAKE];
		end
	end
	wire in_frame = !sy2[SY_CSN];
	wire frame_start = csn_d && !sy2[SY_CSN];
	wire frame_end = !csn_d && sy2[SY_CSN];
	wire sck_rise = in_frame && !sck_d && sy2[SY_SCK];
	wire sck_fall = in_frame && sck_d && !sy2[SY_SCK];
	wire wake_fall = wake_d && !sy2[SY_WAKE];

	////////////////////////////////////////////////////////////////////////////////
	// Serial frame
	logic [FRAME_BITS-1:0] shreg;
	logic [CNT_W-1:0] bit_cnt;
	logic [EN_W-1:0] snap;
	logic [EN_W-1:0] en;
	logic [EN_W-1:0] flags;
	wire [1:0] addr = shreg[POS_ADDR_HI:POS_ADDR_LO];
	wire [1:0] hdr_addr = shreg[2:1];
	wire hdr_rrs = shreg[0];
	wire [EN_W-1:0] rb_word = hdr_rrs ? flags : en; // see [RULE2] [RULE23]
	wire frame_ok = frame_end && bit_cnt == CNT_FULL; // see [RULE9]
	wire frame_bad = frame_end && bit_cnt != CNT_FULL; // see [RULE9]
	wire hit = frame_ok && addr == ADDR_IRQ; // see [RULE1]
	wire en_write = hit && !shreg[POS_RO]; // see [RULE3]
	wire flag_read = hit && shreg[POS_RRS]; // see [RULE19]
	wire [3:0] out_idx = 4'(FRAME_BITS - 1) - bit_cnt[3:0];
	wire out_bit = (bit_cnt >= CNT_DATA && bit_cnt < CNT_FULL) ? snap[out_idx] : 1'b0;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			shreg <= '0;
			bit_cnt <= '0;
			snap <= '0;
		end else if (frame_start) begin
			shreg <= '0;
			bit_cnt <= '0;
		end else if (sck_rise) begin
			shreg <= {shreg[FRAME_BITS-2:0], sy2[SY_SDI]};
			bit_cnt <= (bit_cnt == CNT_MAX) ? CNT_MAX : bit_cnt + 1'b1;
			if (bit_cnt == CNT_ADDR) begin
				snap <= '0;
			end
		end else if (bit_cnt == CNT_SEL && in_frame) begin
			snap <= rb_word; // see [RULE2]
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
		end else begin
			sdo_oe <= in_frame && bit_cnt >= CNT_ADDR && hdr_addr == ADDR_IRQ; // see [RULE1]
			if (frame_start) begin
				sdo <= 1'b0;
			end else if (sck_fall) begin
				sdo <= out_bit;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Event detection
	logic tws_d;
	logic gsd_d;
	logic [2:0] sup_d;
	logic [3:0] canf_d;
	logic [1:0] linf_d;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tws_d <= 1'b0;
			gsd_d <= 1'b0;
			sup_d <= 3'h7;
			canf_d <= 4'h0;
			linf_d <= 2'h0;
		end else begin
			tws_d <= evt.temp_warning_status;
			gsd_d <= evt.ground_shift;
			sup_d <= {evt.supply3_diag, evt.supply2_diag, evt.supply1_diag};
			canf_d <= evt.can_fail_code;
			linf_d <= evt.lin_fail_code;
		end
	end
	wire m_stby = op_mode == SIE_STANDBY;
	wire m_nf = op_mode == SIE_NORMAL || op_mode == SIE_FLASH;
	wire m_boot = op_mode == SIE_STARTUP || op_mode == SIE_RESTART;
	wire [2:0] sup_now = {evt.supply3_diag, evt.supply2_diag, evt.supply1_diag};
	wire lw = wake_fall && wake_port_en; // see [RULE15]
	wire wdt_irq = evt.wd_overflow && m_stby && en[B_WDT]; // see [RULE4]
	wire clk_irq = frame_bad && en[B_CLK] && !m_boot; // see [RULE8]
	logic [EN_W-1:0] set_vec;
	always_comb begin
		set_vec = '0;
		set_vec[B_WDT] = wdt_irq;
		set_vec[B_TEMP] = en[B_TEMP] && (tws_d != evt.temp_warning_status); // see [RULE6]
		set_vec[B_GND] = en[B_GND] && (gsd_d != evt.ground_shift); // see [RULE7]
		set_vec[B_CLK] = clk_irq;
		set_vec[B_SUP] = en[B_SUP] && |(sup_d & ~sup_now); // see [RULE11]
		set_vec[B_CANF] = en[B_CANF] && (canf_d != evt.can_fail_code); // see [RULE12]
		set_vec[B_LINF] = en[B_LINF] && (linf_d != evt.lin_fail_code); // see [RULE13]
		set_vec[B_WAKE] = lw && en[B_WAKE] && (m_nf || m_stby); // see [RULE14]
		set_vec[B_WDR] = en[B_WDR] && evt.wd_restart_off; // see [RULE16]
		set_vec[B_CANW] = evt.can_wake && en[B_CANW]
			&& (m_stby || (m_nf && !evt.can_active)); // see [RULE17]
		set_vec[B_LINW] = evt.lin_wake && en[B_LINW]
			&& (m_stby || (m_nf && !evt.lin_active)); // see [RULE18]
	end
	wire next_reset_req = (evt.wd_overflow && !wdt_irq) // see [RULE4]
		|| (frame_bad && en[B_CLK] && m_boot) // see [RULE8]
		|| (m_stby && lw && !en[B_WAKE]) // see [RULE14]
		|| (m_stby && evt.can_wake && !en[B_CANW]) // see [RULE17]
		|| (m_stby && evt.lin_wake && !en[B_LINW]); // see [RULE18]

	////////////////////////////////////////////////////////////////////////////////
	// Enable register and cause flags
	logic bat_pend;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			en <= EN_RESET;
			flags <= '0;
			bat_pend <= 1'b0;
			reset_req <= 1'b0;
		end else begin
			reset_req <= next_reset_req;
			if (en_write) begin
				en <= shreg[EN_W-1:0]; // see [RULE3]
			end else if (evt.wd_overflow) begin
				en[B_WDT] <= 1'b0; // see [RULE5]
			end
			flags <= (flags & ~(flag_read ? snap : '0)) | set_vec; // see [RULE19]
			bat_pend <= evt.bat_fail || (bat_pend && !flag_read);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt pin with release time and rate limit
	localparam int RC_W = $clog2(REL_CYCLES + 1);
	logic [RC_W-1:0] rel_cnt;
	logic nc_block;
	wire rel_busy = rel_cnt != '0;
	wire crit_pend = flags[B_CLK] || bat_pend || flags[B_WDT] || flags[B_WDR]; // see [RULE21]
	wire nc_pend = |(flags & NC_MASK);
	wire nc_ok = !irq_out_n || op_mode != SIE_NORMAL || !nc_block; // see [RULE22]
	// A flag read releases the pin at once, on the same edge that loads the release counter
	wire next_irq_n = !(!rel_busy && !flag_read
		&& (crit_pend || (nc_pend && nc_ok))); // see [RULE24] [RULE20]
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rel_cnt <= '0;
			nc_block <= 1'b0;
			irq_out_n <= 1'b1;
		end else begin
			if (flag_read) begin
				rel_cnt <= RC_W'(REL_CYCLES); // see [RULE20]
			end else if (rel_busy) begin
				rel_cnt <= rel_cnt - 1'b1;
			end
			if (evt.wd_period_tick) begin
				nc_block <= 1'b0;
			end else if (!next_irq_n && nc_pend && op_mode == SIE_NORMAL) begin
				nc_block <= 1'b1; // see [RULE22]
			end
			irq_out_n <= next_irq_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_valid_read;
		flag_read && set_vec == '0;
	endsequence

	a_bad_frame_keeps: assert property (frame_bad && !evt.wd_overflow |=> $stable(en)) // see [RULE9]
		else $error("enables changed by a bad frame");
	a_ro_keeps_en: assert property (hit && shreg[POS_RO] && !evt.wd_overflow |=> $stable(en)) // see [RULE3]
		else $error("read-only frame changed enables");
	a_write_loads: assert property (en_write |=> en == $past(shreg[EN_W-1:0])) // see [RULE3]
		else $error("enable write not loaded");
	a_ovf_clears_en: assert property (evt.wd_overflow && !en_write |=> !en[B_WDT]) // see [RULE5]
		else $error("timeout enable not cleared on overflow");
	a_read_clears: assert property (s_valid_read |=> (flags & $past(snap)) == '0) // see [RULE19]
		else $error("read flags not cleared");
	a_keep_new: assert property (flag_read |=> (flags & $past(set_vec)) == $past(set_vec)) // see [RULE19]
		else $error("cause lost during read");
	a_release_high: assert property (flag_read |=> irq_out_n [*8]) // see [RULE20]
		else $error("pin not released after read");
	a_crit_fast: assert property (flags[B_CLK] && !rel_busy && !flag_read |-> ##[0:1] !irq_out_n) // see [RULE21]
		else $error("critical cause not signalled");
	a_wake_gate: assert property (!wake_port_en |-> !set_vec[B_WAKE]) // see [RULE15]
		else $error("local wake acted while port disabled");
	a_ovf_reset: assert property (evt.wd_overflow && !(m_stby && en[B_WDT]) |=> reset_req) // see [RULE4]
		else $error("overflow did not request reset");
	a_clk_fail_irq: assert property (frame_bad && en[B_CLK] && !m_boot |=> flags[B_CLK]) // see [RULE8]
		else $error("clock count failure not flagged");
endmodule : sie_irq

// ### sie_pkg.sv
// Constants, modes and event bundle for the interrupt enable and flag logic
package sie_pkg;
	localparam int FRAME_BITS = 16;
	localparam int EN_W = 12;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
	localparam logic [CNT_W-1:0] CNT_SEL = 5'h03;
	localparam logic [CNT_W-1:0] CNT_ADDR = 5'h02;
	localparam logic [CNT_W-1:0] CNT_DATA = 5'h04;
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
	// Frame header fields
	localparam int POS_ADDR_HI = 15;
	localparam int POS_ADDR_LO = 14;
	localparam int POS_RRS = 13;
	localparam int POS_RO = 12;
	localparam logic [1:0] ADDR_IRQ = 2'h1;
	// Enable and flag positions
	localparam int B_WDT = 11;
	localparam int B_TEMP = 10;
	localparam int B_GND = 9;
	localparam int B_CLK = 8;
	localparam int B_RSVD = 7;
	localparam int B_SUP = 6;
	localparam int B_CANF = 5;
	localparam int B_LINF = 4;
	localparam int B_WAKE = 3;
	localparam int B_WDR = 2;
	localparam int B_CANW = 1;
	localparam int B_LINW = 0;
	localparam logic [EN_W-1:0] EN_RESET = 12'h000;
	// Sources held back to one pin assertion per watchdog period in Normal mode
	localparam logic [EN_W-1:0] NC_MASK = 12'h0_67b;
	// Interrupt pin release time after a flag read
	localparam int REL_NS = 20_000;
	localparam int CLK_NS = 40;
	localparam int REL_CYC = (REL_NS + CLK_NS - 1) / CLK_NS;
	// Synchroniser lanes
	localparam int SY_SCK = 0;
	localparam int SY_CSN = 1;
	localparam int SY_SDI = 2;
	localparam int SY_WAKE = 3;

	typedef enum logic [2:0] {
		SIE_STARTUP = 3'b000,
		SIE_RESTART = 3'b001,
		SIE_STANDBY = 3'b010,
		SIE_NORMAL = 3'b011,
		SIE_FLASH = 3'b100,
		SIE_SLEEP = 3'b101
	} sie_mode_t;

	typedef struct packed {
		logic wd_overflow;
		logic wd_restart_off;
		logic wd_period_tick;
		logic temp_warning_status;
		logic ground_shift;
		logic supply1_diag;
		logic supply2_diag;
		logic supply3_diag;
		logic [3:0] can_fail_code;
		logic [1:0] lin_fail_code;
		logic can_wake;
		logic can_active;
		logic lin_wake;
		logic lin_active;
		logic bat_fail;
	} sie_evt_t;
endpackage : sie_pkg

// ### sie_host_model.sv
// Host serial master model that frames words into the block
`timescale 1ns/100ps
module sie_host_model (
	input wire logic mclk, // System clock pacing the link
	input wire logic sdo, // Serial data from the block
	output logic sck, // Serial clock, still between frames
	output logic scs_n, // Chip select, active low
	output logic sdi // Serial data to the block
);
	initial begin
		sck = 1'b0;
		scs_n = 1'b1;
		sdi = 1'b1;
	end
	//////////////////////////////////////////////////////////////////////////////
	// Half of the 320 ns link period is four system cycles
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
		rd = 16'h0000;
		@(negedge mclk);
		scs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi = w[15 - (i % 16)];
			repeat (4) @(negedge mclk);
			sck = 1'b1;
			repeat (4) @(negedge mclk);
			rd = {rd[14:0], sdo};
			sck = 1'b0;
		end
		repeat (4) @(negedge mclk);
		scs_n = 1'b1;
		sdi = ~sdi;
		repeat (8) @(negedge mclk);
	endtask : xfer
endmodule : sie_host_model

// ### test_sie_irq.sv
// Self-checking bench for the interrupt enable and flag block
`timescale 1ns/100ps
module test_sie_irq import sie_pkg::*; ;
	localparam int REL = 20;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic sck, scs_n, sdi, sdo, sdo_oe, irq_out_n, reset_req;
	logic local_wake_pin, wake_port_en;
	sie_mode_t op_mode;
	sie_evt_t evt;
	int n_mismatch = 0;
	int compares = 0;
	int n_rst = 0;
	int x;
	logic [11:0] en_m = 12'h000;
	logic [11:0] fl_m = 12'h000;
	logic [15:0] rd;
	always #20 mclk = ~mclk;
	always @(posedge mclk) if (reset_req === 1'b1) n_rst++;
	sie_irq #(.REL_CYCLES(REL)) dut (.mclk(mclk), .rst(rst), .sck(sck), .scs_n(scs_n),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .local_wake_pin(local_wake_pin),
		.wake_port_en(wake_port_en), .op_mode(op_mode), .evt(evt),
		.irq_out_n(irq_out_n), .reset_req(reset_req));
	sie_host_model host (.mclk(mclk), .sdo(sdo), .sck(sck), .scs_n(scs_n), .sdi(sdi));
	//////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic pin(input logic v);
		check({15'h0000, irq_out_n}, {15'h0000, v});
	endtask : pin
	// Read enables (sel 0) or cause flags (sel 1)
	task automatic rd_chk(input logic sel);
		host.xfer({2'b01, sel, 1'b1, 12'h000}, 16, rd);
		check(rd, {4'h0, sel ? fl_m : en_m});
		check({15'h0000, sdo_oe}, 16'h0000);
		if (sel) fl_m = 12'h000;
	endtask : rd_chk
	task automatic wr_en(input logic [11:0] v);
		host.xfer({4'b0100, v & 12'hf7f}, 16, rd);
		check(rd, {4'h0, en_m});
		en_m = v & 12'hf7f;
	endtask : wr_en
	task automatic ev(input int b);
		@(negedge mclk);
		case (b)
			12: evt.wd_period_tick = 1'b1;
			11: evt.wd_overflow = 1'b1;
			10: evt.temp_warning_status = ~evt.temp_warning_status;
			9: evt.ground_shift = ~evt.ground_shift;
			8: host.xfer(16'h4000, 15, rd);
			6: evt.supply2_diag = 1'b0;
			5: evt.can_fail_code = evt.can_fail_code + 4'h1;
			4: evt.lin_fail_code = evt.lin_fail_code + 2'h1;
			3: local_wake_pin = 1'b0;
			2: evt.wd_restart_off = 1'b1;
			1: evt.can_wake = 1'b1;
			0: evt.lin_wake = 1'b1;
			default: ;
		endcase
		@(negedge mclk);
		{evt.wd_overflow, evt.wd_restart_off, evt.can_wake, evt.lin_wake} = 4'h0;
		evt.wd_period_tick = 1'b0;
		evt.supply2_diag = 1'b1;
		repeat (4) @(negedge mclk);
		local_wake_pin = 1'b1;
		repeat (4) @(negedge mclk);
	endtask : ev
	task automatic stop_test;
		if (n_mismatch == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hbfb7));
		op_mode = SIE_STANDBY;
		evt = '0;
		{evt.supply1_diag, evt.supply2_diag, evt.supply3_diag} = 3'h7;
		local_wake_pin = 1'b1;
		wake_port_en = 1'b1;
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		pin(1'b1);
		rd_chk(1'b0);
		for (int k = 0; k < 4; k++) begin
			wr_en(12'($urandom));
			rd_chk(1'b0);
		end
		host.xfer({4'b0111, 12'hfff}, 16, rd);
		for (int a = 0; a < 4; a++) begin
			if (a != 1) host.xfer({2'(a), 2'b00, 12'h0a5}, 16, rd);
		end
		rd_chk(1'b0);
		wr_en(12'h000);
		host.xfer({4'b0100, 12'hfff}, 15, rd);
		host.xfer({4'b0100, 12'hfff}, 17, rd);
		rd_chk(1'b0);
		op_mode = SIE_STARTUP;
		wr_en(12'h100);
		x = n_rst;
		ev(8);
		check(16'(n_rst - x), 16'h0001);
		rd_chk(1'b1);
		op_mode = SIE_STANDBY;
		wr_en(12'hf7f);
		for (int b = 11; b >= 0; b--) begin
			if (b != 7) ev(b);
			if (b != 7) fl_m[b] = 1'b1;
		end
		en_m[11] = 1'b0;
		pin(1'b0);
		rd_chk(1'b0);
		rd_chk(1'b1);
		ev(1);
		fl_m[1] = 1'b1;
		pin(1'b1);
		repeat (REL) @(negedge mclk);
		pin(1'b0);
		rd_chk(1'b1);
		wr_en(12'h000);
		x = n_rst;
		ev(1);
		ev(11);
		ev(3);
		check(16'(n_rst - x), 16'h0003);
		op_mode = SIE_NORMAL;
		ev(1);
		wake_port_en = 1'b0;
		wr_en(12'h00a);
		ev(3);
		evt.can_active = 1'b1;
		ev(1);
		check(16'(n_rst - x), 16'h0003);
		rd_chk(1'b1);
		evt.can_active = 1'b0;
		wr_en(12'h120);
		ev(5);
		fl_m[5] = 1'b1;
		pin(1'b0);
		rd_chk(1'b1);
		repeat (REL) @(negedge mclk);
		ev(5);
		fl_m[5] = 1'b1;
		pin(1'b1);
		ev(12);
		pin(1'b0);
		rd_chk(1'b1);
		repeat (REL) @(negedge mclk);
		ev(5);
		ev(8);
		fl_m[5] = 1'b1;
		fl_m[8] = 1'b1;
		pin(1'b0);
		rd_chk(1'b1);
		stop_test();
	end
endmodule : test_sie_irq
